// ==== core/pmb_pkg.sv ====
// package for the program memory bus and long write block
package pmb_pkg;
    localparam int PMB_AW = 16;
    localparam int PMB_BW = 8;
    localparam int PMB_CTL_ALE = 0;
    localparam int PMB_CTL_OE = 1;
    localparam int PMB_CTL_WR = 2;
    localparam int PMB_CTL_W = 3;
    localparam logic [1:0] PMB_MODE_MICROPROC = 2'h0;
    localparam logic [1:0] PMB_MODE_EXT_MCU = 2'h1;
    localparam logic [1:0] PMB_MODE_MCU = 2'h2;
    localparam logic [1:0] PMB_MODE_SECURE = 2'h3;
    localparam logic [1:0] PMB_PH_Q1 = 2'h0;
    localparam logic [1:0] PMB_PH_Q2 = 2'h1;
    localparam logic [1:0] PMB_PH_Q3 = 2'h2;
    localparam logic [1:0] PMB_PH_Q4 = 2'h3;
    localparam logic [1:0] PMB_SHORT_WRITE_CYCLES = 2'h2;
    localparam logic [15:0] PMB_ADDR_RESET = 16'h0000;
    typedef enum logic [3:0] {
        PMB_ST_IDLE = 4'b0001,
        PMB_ST_BUSCYC = 4'b0010,
        PMB_ST_LONGWR = 4'b0100,
        PMB_ST_SHORTWR = 4'b1000
    } pmb_state_t;
endpackage

// ==== core/pmb_phase.sv ====
// four-phase instruction cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module pmb_phase
    import pmb_pkg::*;
(
    input wire logic clk, // clock
    input wire logic rst, // synchronous reset
    input wire logic run, // advance phases
    output logic [1:0] phase, // current phase
    output logic last // phase q4 this cycle
);
    logic [1:0] phase_reg;
    logic [1:0] phase_next;
    assign phase_next = run ? phase_reg + 2'h1 : PMB_PH_Q1;
    assign phase = phase_reg;
    assign last = run && (phase_reg == PMB_PH_Q4);
    always_ff @(posedge clk)
    begin
        if (rst)
            phase_reg <= PMB_PH_Q1;
        else
            phase_reg <= phase_next;
    end
endmodule
`default_nettype wire

// ==== core/pmb_top.sv ====
// system bus master and long table write control
`timescale 1ns/1ps
`default_nettype none
module pmb_top
    import pmb_pkg::*;
#(
    parameter int AW = PMB_AW
)
(
    input wire logic REF_CLK, // clock
    input wire logic RST, // synchronous reset, active high
    input wire logic [1:0] MODE, // processor mode select
    input wire logic REQ, // start bus cycle, level held while BUSY low
    input wire logic REQ_WRITE, // request is a write
    input wire logic REQ_TABLE, // request is a table write
    input wire logic REQ_INTERNAL, // target is internal memory
    input wire logic [AW-1:0] REQ_ADDR, // access address
    input wire logic [AW-1:0] REQ_WDATA, // write data
    input wire logic [AW-1:0] INT_RDATA, // internal memory read data
    input wire logic VPP_OK, // programming voltage present on reset_program_voltage_pin
    input wire logic INT_PENDING, // an enabled interrupt source is active
    output logic BUSY, // cycle in progress, execution stalled
    output logic DONE, // one-cycle pulse at end of access
    output logic [AW-1:0] RDATA, // read data
    output logic PROG_WRITE, // pulse: write program memory cell
    output logic LONG_WRITE, // long write in progress
    output logic BUS_MODE, // ports are the system bus
    input wire logic [PMB_BW-1:0] LOW_DATA_PORT_I, // low_data_port pins in
    output logic [PMB_BW-1:0] LOW_DATA_PORT_O, // low_data_port pins out
    output logic LOW_DATA_PORT_OE, // low_data_port drive
    input wire logic [PMB_BW-1:0] HIGH_DATA_PORT_I, // high_data_port pins in
    output logic [PMB_BW-1:0] HIGH_DATA_PORT_O, // high_data_port pins out
    output logic HIGH_DATA_PORT_OE, // high_data_port drive
    output logic [PMB_CTL_W-1:0] CONTROL_PORT_O, // control_port bits 2:0
    output logic CONTROL_PORT_OE // control_port drive
);
    pmb_state_t state_reg, state_next;
    logic [AW-1:0] addr_reg, wdata_reg, rdata_reg;
    logic wr_reg, int_reg;
    logic done_reg, prog_reg;
    logic [1:0] cnt_reg;
    logic [1:0] phase;
    logic last;
    logic run;
    logic ale_reg, oe_n_reg, wr_n_reg, drive_reg, data_phase_reg;
    wire bus_en = (MODE == PMB_MODE_MICROPROC) || (MODE == PMB_MODE_EXT_MCU);
    wire start = (state_reg == PMB_ST_IDLE) && REQ;
    wire tbl_int = REQ_TABLE && REQ_WRITE && REQ_INTERNAL;
    wire in_bus = state_reg == PMB_ST_BUSCYC;
    wire late = (phase == PMB_PH_Q3) || (phase == PMB_PH_Q4);
    // ALE decoded in q1 and registered, so high in q2, falls into q3 with address still driven
    wire ale_next = in_bus && (phase == PMB_PH_Q1);
    wire oe_n_next = !(in_bus && !wr_reg && late);
    wire wr_n_next = !(in_bus && wr_reg && late);
    wire drive_next = in_bus && (!late || wr_reg);
    wire [AW-1:0] bus_sample = {HIGH_DATA_PORT_I, LOW_DATA_PORT_I};
    // internal fetch still runs the strobes but pins are not used for data
    wire [AW-1:0] read_src = int_reg ? INT_RDATA : bus_sample;
    wire [AW-1:0] pins_out = data_phase_reg ? wdata_reg : addr_reg;
    assign run = in_bus;

    pmb_phase u_phase (
        .clk(REF_CLK),
        .rst(RST),
        .run(run),
        .phase(phase),
        .last(last)
    );

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            PMB_ST_IDLE:
            begin
                if (REQ && tbl_int && VPP_OK && !INT_PENDING)
                    state_next = PMB_ST_LONGWR;
                else if (REQ && tbl_int)
                    state_next = PMB_ST_SHORTWR;
                else if (REQ)
                    state_next = PMB_ST_BUSCYC;
            end
            PMB_ST_BUSCYC:
                if (last)
                    state_next = PMB_ST_IDLE;
            PMB_ST_LONGWR:
                if (INT_PENDING)
                    state_next = PMB_ST_IDLE;
            PMB_ST_SHORTWR:
                if (cnt_reg == PMB_SHORT_WRITE_CYCLES - 2'h1)
                    state_next = PMB_ST_IDLE;
            default:
                state_next = PMB_ST_IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            state_reg <= PMB_ST_IDLE;
            addr_reg <= PMB_ADDR_RESET;
            wdata_reg <= PMB_ADDR_RESET;
            wr_reg <= 1'b0;
            int_reg <= 1'b0;
            cnt_reg <= 2'h0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= (state_reg == PMB_ST_SHORTWR) ? cnt_reg + 2'h1 : 2'h0;
            if (start)
            begin
                addr_reg <= REQ_ADDR;
                wdata_reg <= REQ_WDATA;
                wr_reg <= REQ_WRITE;
                // every mode but microprocessor reaches internal memory but still cycles the bus
                int_reg <= REQ_INTERNAL || (MODE != PMB_MODE_MICROPROC);
            end
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            ale_reg <= 1'b0;
            oe_n_reg <= 1'b1;
            wr_n_reg <= 1'b1;
            drive_reg <= 1'b0;
            data_phase_reg <= 1'b0;
        end
        else
        begin
            ale_reg <= ale_next;
            oe_n_reg <= oe_n_next;
            wr_n_reg <= wr_n_next;
            drive_reg <= drive_next;
            data_phase_reg <= in_bus && late && wr_reg;
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            rdata_reg <= PMB_ADDR_RESET;
            done_reg <= 1'b0;
            prog_reg <= 1'b0;
        end
        else
        begin
            if (last && !wr_reg)
                rdata_reg <= read_src;
            done_reg <= (state_reg != PMB_ST_IDLE) && (state_next == PMB_ST_IDLE);
            // cell written only at end of a powered long write
            prog_reg <= (state_reg == PMB_ST_LONGWR) && INT_PENDING;
        end
    end

    // pins are general purpose (released here) outside the bus modes
    assign BUS_MODE = bus_en;
    assign LOW_DATA_PORT_O = pins_out[PMB_BW-1:0];
    assign HIGH_DATA_PORT_O = pins_out[AW-1:PMB_BW];
    assign LOW_DATA_PORT_OE = bus_en && drive_reg;
    assign HIGH_DATA_PORT_OE = bus_en && drive_reg;
    assign CONTROL_PORT_O[PMB_CTL_ALE] = ale_reg;
    assign CONTROL_PORT_O[PMB_CTL_OE] = oe_n_reg;
    assign CONTROL_PORT_O[PMB_CTL_WR] = wr_n_reg;
    assign CONTROL_PORT_OE = bus_en;
    assign BUSY = state_reg != PMB_ST_IDLE;
    assign LONG_WRITE = state_reg == PMB_ST_LONGWR;
    assign DONE = done_reg;
    assign RDATA = rdata_reg;
    assign PROG_WRITE = prog_reg;

    a_long_write_ends: assert property (@(posedge REF_CLK) disable iff (RST)
        (state_reg == PMB_ST_LONGWR) && INT_PENDING |=> (state_reg == PMB_ST_IDLE) && DONE && PROG_WRITE)
        else $error("long write not ended by interrupt");
    a_short_write_len: assert property (@(posedge REF_CLK) disable iff (RST)
        (state_reg == PMB_ST_IDLE) && REQ && tbl_int && !VPP_OK
        |=> (state_reg == PMB_ST_SHORTWR) [*2] ##1 (state_reg == PMB_ST_IDLE) && !PROG_WRITE)
        else $error("unpowered table write not two cycles");
    a_long_write_start: assert property (@(posedge REF_CLK) disable iff (RST)
        (state_reg == PMB_ST_IDLE) && REQ && tbl_int && VPP_OK && !INT_PENDING |=> BUSY && LONG_WRITE)
        else $error("long write not started");
    a_ale_fall_addr: assert property (@(posedge REF_CLK) disable iff (RST)
        $fell(CONTROL_PORT_O[PMB_CTL_ALE]) |-> LOW_DATA_PORT_OE && $stable(LOW_DATA_PORT_O)
        && $stable(HIGH_DATA_PORT_O))
        else $error("address not held across latch strobe fall");
    a_oe_read_only: assert property (@(posedge REF_CLK) disable iff (RST)
        !CONTROL_PORT_O[PMB_CTL_OE] |-> !LOW_DATA_PORT_OE && CONTROL_PORT_O[PMB_CTL_WR])
        else $error("output enable with bus driven");
    a_wr_data_driven: assert property (@(posedge REF_CLK) disable iff (RST)
        !CONTROL_PORT_O[PMB_CTL_WR] |-> HIGH_DATA_PORT_OE && (pins_out == wdata_reg))
        else $error("write strobe without data");
    a_bus_cycle_len: assert property (@(posedge REF_CLK) disable iff (RST)
        (state_reg == PMB_ST_IDLE) && REQ && !tbl_int |=> in_bus [*4] ##1 (!in_bus && DONE))
        else $error("bus cycle not four phases");
    a_ports_mode: assert property (@(posedge REF_CLK) disable iff (RST)
        !bus_en |-> !CONTROL_PORT_OE && !LOW_DATA_PORT_OE && !HIGH_DATA_PORT_OE)
        else $error("ports driven outside bus modes");
endmodule
`default_nettype wire

// ==== dv/pmb_ext_mem.sv ====
// external address latch and word memory on the multiplexed bus
`timescale 1ns/1ps
`default_nettype none
module pmb_ext_mem
    import pmb_pkg::*;
(
    input wire logic [PMB_CTL_W-1:0] ctl, // bus strobes
    input wire logic [1:0] dev_oe, // device drives high, low byte
    input wire logic [PMB_AW-1:0] dev_o, // device outputs
    output logic [PMB_AW-1:0] pins // resolved bus lines
);
    logic [PMB_AW-1:0] latch_reg = 16'h0000;
    logic [PMB_AW-1:0] wdat = 16'h0000;
    logic [PMB_AW-1:0] last = 16'h0000;
    logic [PMB_AW-1:0] mem [0:255];
    logic [PMB_AW-1:0] far;
    logic rd;
    assign rd = ~ctl[PMB_CTL_OE];
    // released lines show the inverse of the last value, so a stale read cannot pass
    assign far = rd ? mem[latch_reg[7:0]] : ~last;
    assign pins = {dev_oe[1] ? dev_o[15:8] : far[15:8], dev_oe[0] ? dev_o[7:0] : far[7:0]};
    always @(negedge ctl[PMB_CTL_ALE]) latch_reg = pins;
    always @* if (dev_oe != 2'b00 || rd) last = pins;
    // data taken just after the strobe falls, clear of the edge that launches both
    always @(negedge ctl[PMB_CTL_WR]) #1 if (dev_oe == 2'b11) wdat = dev_o;
    always @(posedge ctl[PMB_CTL_WR]) mem[latch_reg[7:0]] = wdat;
endmodule
`default_nettype wire

// ==== dv/program_memory_bus_and_long_write_tb_top.sv ====
// bench for the program memory bus and long write block
`timescale 1ns/1ps
`default_nettype none
module program_memory_bus_and_long_write_tb_top
    import pmb_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, req = 1'b0, wr = 1'b0, tbl = 1'b0, intl = 1'b0, vpp = 1'b0, irq = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [15:0] addr = 16'h0000, wdat = 16'h0000, irdat = 16'h0000, rdat, pins, adr_seen;
    logic busy, done, pw, lw, bm, lo_oe, hi_oe, c_oe, oe_seen, pw_seen;
    logic [7:0] lo_o, hi_o;
    logic [2:0] ctl, hold_seen;
    logic [2:0] ctl_log [0:7];
    int mismatches = 0, total_checks = 0, cyc = 0, n;
    always #4 clk = ~clk;
    pmb_top DUT (.REF_CLK(clk), .RST(rst), .MODE(mode), .REQ(req), .REQ_WRITE(wr), .REQ_TABLE(tbl),
        .REQ_INTERNAL(intl), .REQ_ADDR(addr), .REQ_WDATA(wdat), .INT_RDATA(irdat), .VPP_OK(vpp),
        .INT_PENDING(irq), .BUSY(busy), .DONE(done), .RDATA(rdat), .PROG_WRITE(pw), .LONG_WRITE(lw),
        .BUS_MODE(bm), .LOW_DATA_PORT_I(pins[7:0]), .LOW_DATA_PORT_O(lo_o), .LOW_DATA_PORT_OE(lo_oe),
        .HIGH_DATA_PORT_I(pins[15:8]), .HIGH_DATA_PORT_O(hi_o), .HIGH_DATA_PORT_OE(hi_oe),
        .CONTROL_PORT_O(ctl), .CONTROL_PORT_OE(c_oe));
    pmb_ext_mem mem_i (.ctl(ctl), .dev_oe({hi_oe, lo_oe}), .dev_o({hi_o, lo_o}), .pins(pins));
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // one access: n ends as the number of edges from take to the done pulse
    task automatic run(input logic w, t, i, input logic [15:0] a, d, input int int_at);
        @(negedge clk);
        {req, wr, tbl, intl, addr, wdat} = {1'b1, w, t, i, a, d};
        @(posedge clk);
        n = 0;
        pw_seen = 1'b0;
        do
        begin
            @(negedge clk);
            n++;
            if (n < 8) ctl_log[n] = ctl;
            if (n == 2) adr_seen = {hi_o, lo_o};
            if (n == 4) oe_seen = lo_oe & hi_oe;
            if (n == int_at - 1) hold_seen = {busy, lw, done};
            if (n == int_at) irq = 1'b1;
            pw_seen |= pw;
        end
        while (done !== 1'b1 && n < 400);
        req = 1'b0;
        irq = 1'b0;
        // one more cycle so the strobes are seen back at rest after the pulse
        @(negedge clk);
        if (n < 7) ctl_log[n + 1] = ctl;
    endtask
    function automatic logic [2:0] exp_ctl(input logic w, input int k);
        case (k)
            2: return 3'h7;
            4, 5: return w ? 3'h2 : 3'h4;
            default: return 3'h6;
        endcase
    endfunction
    task automatic t_modes();
        for (int m = 0; m < 4; m++)
        begin
            @(negedge clk);
            mode = m[1:0];
            #1;
            cmp({bm, c_oe}, (m < 2) ? 16'h0003 : 16'h0000);
        end
    endtask
    task automatic t_ext();
        mode = PMB_MODE_MICROPROC;
        for (int w = 1; w >= 0; w--)
        begin
            run(w[0], 1'b0, 1'b0, 16'h0312, 16'hbeef, 0);
            cmp(16'(n), 16'h0005);
            for (int k = 1; k < 7; k++) cmp(ctl_log[k], exp_ctl(w[0], k));
            cmp(adr_seen, 16'h0312);
            cmp(oe_seen, w[0]);
            cmp(mem_i.latch_reg, 16'h0312);
        end
        cmp(mem_i.mem[8'h12], 16'hbeef);
        cmp(rdat, 16'hbeef);
    endtask
    task automatic t_internal();
        mode = PMB_MODE_EXT_MCU;
        irdat = 16'h5a3c;
        run(1'b0, 1'b0, 1'b1, 16'h0040, 16'h0000, 0);
        cmp(16'(n), 16'h0005);
        cmp(ctl_log[4], 16'h0004);
        cmp(rdat, 16'h5a3c);
    endtask
    task automatic t_table();
        mode = PMB_MODE_MCU;
        vpp = 1'b1;
        run(1'b1, 1'b1, 1'b1, 16'h0100, 16'h0abc, 20);
        cmp(hold_seen, 16'h0006);
        cmp(16'(n == 21 || n == 22), 16'h0001);
        cmp(pw_seen, 16'h0001);
        irq = 1'b1;
        run(1'b1, 1'b1, 1'b1, 16'h0100, 16'h0abc, 0);
        cmp(16'(n), 16'h0003);
        cmp(pw_seen, 16'h0000);
        vpp = 1'b0;
        run(1'b1, 1'b1, 1'b1, 16'h0100, 16'h0abc, 0);
        cmp(16'(n), 16'h0003);
        cmp(pw_seen, 16'h0000);
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        cmp({busy, done, ctl, lo_oe, hi_oe}, 16'h0018);
        t_modes();
        t_ext();
        t_internal();
        t_table();
        finish_test();
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            mismatches++;
            finish_test();
        end
    end
endmodule
`default_nettype wire
